/* File: logic/fpag_pkg.sv */
// Register map, field positions and constants for the frame pulse and genlock block.
// Assumes one register port with 8-bit addresses and data.
package fpag_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS   = 8'h01;
  localparam logic [7:0] ADDR_OUTCFG   = 8'h08;
  localparam logic [7:0] ADDR_RATIO_LO = 8'h09;
  localparam logic [7:0] ADDR_ALIGN    = 8'h0a;
  localparam logic [7:0] ADDR_PPL_LO   = 8'h0b;
  localparam logic [7:0] ADDR_PPL_HI   = 8'h0c;
  localparam logic [7:0] ADDR_OLPF_LO  = 8'h0d;
  localparam logic [7:0] ADDR_OLPF_HI  = 8'h0e;
  localparam logic [7:0] ADDR_RLPF_LO  = 8'h0f;
  localparam logic [7:0] ADDR_RLPF_HI  = 8'h10;
  localparam logic [7:0] ADDR_OFS_LO   = 8'h11;
  localparam logic [7:0] ADDR_OFS_HI   = 8'h12;
  // Field positions
  localparam int FLOAT_BIT    = 4;
  localparam int ALIGN_EN_BIT = 7;
  localparam int TRIG_BIT     = 6;
  localparam int CLKSEL_BIT   = 7;
  localparam int RATIO_W      = 12;
  localparam int PPL_W        = 15;
  localparam int LINE_W       = 16;
  localparam int MISS_W       = 8;
  // Values after reset
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [7:0] STATUS_PAD   = 8'h00;
  // Lock detector last run count, so a run is three comparison periods
  localparam logic [1:0] LOCK_RUN_LAST = 2'h2;
endpackage

/* File: logic/fpag_wrap_counter.sv */
// Wrapping counter from zero to a programmed last value.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module fpag_wrap_counter
  import fpag_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         clr,
  input  wire logic         step,
  input  wire logic [W-1:0] last,
  // Result
  output logic      [W-1:0] count,
  output logic              wrap
);
  logic [W-1:0] count_ff;

  assign count = count_ff;
  assign wrap  = step && (count_ff == last);

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      count_ff <= '0;
    end else if (wrap) begin
      count_ff <= '0;
    end else if (step) begin
      count_ff <= W'(count_ff + 1'b1);
    end
  end
endmodule
`default_nettype wire

/* File: logic/fpag_lock_filter.sv */
// Lock indication that changes only after a run of agreeing phase comparisons.
// Assumes a one-cycle comparison strobe and a phase error flag valid with it.
`timescale 1ns/100ps
`default_nettype none
module fpag_lock_filter
  import fpag_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Phase comparison
  input  wire logic cmp_tick,
  input  wire logic err_high,
  // Result
  output logic      locked
);
  logic       locked_ff;
  logic [1:0] run_ff;
  logic       against;

  assign locked  = locked_ff;
  assign against = (locked_ff == err_high);

  always_ff @(posedge clk) begin
    if (rst) begin
      locked_ff <= 1'b0;
      run_ff    <= 2'h0;
    end else if (cmp_tick) begin
      if (!against) begin
        run_ff <= 2'h0;
      end else if (run_ff == LOCK_RUN_LAST) begin
        locked_ff <= ~locked_ff;
        run_ff    <= 2'h0;
      end else begin
        run_ff <= 2'(run_ff + 2'h1);
      end
    end
  end

  AST_LOCK_RUN: assert property (@(posedge clk) disable iff (rst)
    ((locked_ff != $past(locked_ff)) && !$past(rst))
    |-> $past(cmp_tick && run_ff == LOCK_RUN_LAST))
    else $error("lock state changed without three agreeing comparisons");
endmodule
`default_nettype wire

/* File: logic/fpag_top.sv */
// Frame pulse generation, reference alignment and genlock status flags.
// Assumes pixel and compare strobes are one-cycle pulses synchronous to REF_CLK.
`timescale 1ns/100ps
`default_nettype none
module fpag_top
  import fpag_pkg::*;
(
  // Clock and reset
  input  wire logic             REF_CLK,
  input  wire logic             RST,
  // Register port
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [7:0]       REG_WDATA,
  output logic      [7:0]       REG_RDATA,
  // Pixel strobes of the two output clocks
  input  wire logic             STD_PIXEL_TICK,
  input  wire logic             HIGH_PIXEL_TICK,
  // Reference detection
  input  wire logic             LINE_COMPARE_TICK,
  input  wire logic             HSYNC_SEEN,
  input  wire logic             HSYNC_MISSED,
  input  wire logic [MISS_W-1:0] LOSS_THRESHOLD,
  input  wire logic             HSYNC_FORMAT_MATCH,
  input  wire logic             DIVIDER_MATCH,
  input  wire logic             VCTRL_IN_RANGE,
  // Lock detection
  input  wire logic             FAST_COMPARE_TICK,
  input  wire logic             BASE_PHASE_ERR_HIGH,
  input  wire logic             FAST_PHASE_ERR_HIGH,
  // Frame pulse and flags
  output logic                  FRAME_PULSE,
  output logic                  FRAME_PULSE_OE,
  output logic                  ALIGN_EVENT,
  output logic                  NO_REF_FLAG,
  output logic                  NO_LOCK_FLAG
);
  logic [7:0]         regs_ff [ADDR_OUTCFG:ADDR_OFS_HI];
  logic [7:0]         rdata_ff;
  logic [7:0]         status;
  logic               float_bit;
  logic               align_en;
  logic               trig_bit;
  logic               clk_sel;
  logic [RATIO_W-1:0] ratio_num;
  logic [PPL_W-1:0]   ppl;
  logic [LINE_W-1:0]  out_lpf;
  logic [LINE_W-1:0]  ref_lpf;
  logic [LINE_W-1:0]  line_ofs;
  logic [LINE_W-1:0]  align_line;
  logic               trig_q_ff;
  logic               trig_rise;
  logic               armed_ff;
  logic               pix_step;
  logic [PPL_W-1:0]   pix_cnt;
  logic               pix_wrap;
  logic [LINE_W-1:0]  line_cnt;
  logic [LINE_W-1:0]  ref_cnt;
  logic               ref_wrap;
  logic [RATIO_W-1:0] ratio_cnt;
  logic [RATIO_W-1:0] ratio_last;
  logic               ref_point;
  logic               align_now;
  logic [MISS_W-1:0]  miss_ff;
  logic               ref_valid;
  logic               base_locked;
  logic               fast_locked;
  logic               pulse_ff;
  logic               oe_ff;
  logic               event_ff;
  logic               no_ref_ff;
  logic               no_lock_ff;

  // Register fields
  assign float_bit  = regs_ff[ADDR_OUTCFG][FLOAT_BIT];
  assign align_en   = regs_ff[ADDR_ALIGN][ALIGN_EN_BIT];
  assign trig_bit   = regs_ff[ADDR_ALIGN][TRIG_BIT];
  assign ratio_num  = {regs_ff[ADDR_ALIGN][3:0], regs_ff[ADDR_RATIO_LO]};
  assign clk_sel    = regs_ff[ADDR_PPL_HI][CLKSEL_BIT];
  assign ppl        = {regs_ff[ADDR_PPL_HI][6:0], regs_ff[ADDR_PPL_LO]};
  assign out_lpf    = {regs_ff[ADDR_OLPF_HI], regs_ff[ADDR_OLPF_LO]};
  assign ref_lpf    = {regs_ff[ADDR_RLPF_HI], regs_ff[ADDR_RLPF_LO]};
  assign line_ofs   = {regs_ff[ADDR_OFS_HI], regs_ff[ADDR_OFS_LO]};
  assign status     = {STATUS_PAD[7:3], fast_locked, base_locked, ref_valid};

  // Register writes
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = ADDR_OUTCFG; i <= ADDR_OFS_HI; i++) begin
        regs_ff[i] <= REG_RESET;
      end
    end else if (REG_WR && REG_ADDR >= ADDR_OUTCFG && REG_ADDR <= ADDR_OFS_HI) begin
      regs_ff[REG_ADDR] <= REG_WDATA;
    end
  end

  // Register reads, unmapped offsets read zero
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_ff <= REG_RESET;
    end else if (REG_RD) begin
      if (REG_ADDR == ADDR_STATUS) begin
        rdata_ff <= status;
      end else if (REG_ADDR >= ADDR_OUTCFG && REG_ADDR <= ADDR_OFS_HI) begin
        rdata_ff <= regs_ff[REG_ADDR];
      end else begin
        rdata_ff <= REG_RESET;
      end
    end
  end

  // Pixel strobe selection
  assign pix_step = clk_sel ? HIGH_PIXEL_TICK : STD_PIXEL_TICK;

  // Output frame counters, free running also without reference
  fpag_wrap_counter #(.W(PPL_W)) u_pixel (
    .clk   (REF_CLK),
    .rst   (RST),
    .clr   (align_now),
    .step  (pix_step),
    .last  (PPL_W'(ppl - 1'b1)),
    .count (pix_cnt),
    .wrap  (pix_wrap)
  );

  fpag_wrap_counter #(.W(LINE_W)) u_line (
    .clk   (REF_CLK),
    .rst   (RST),
    .clr   (align_now),
    .step  (pix_wrap),
    .last  (LINE_W'(out_lpf - 1'b1)),
    .count (line_cnt),
    .wrap  ()
  );

  // Reference frame from divided compare lines
  fpag_wrap_counter #(.W(LINE_W)) u_ref (
    .clk   (REF_CLK),
    .rst   (RST),
    .clr   (1'b0),
    .step  (LINE_COMPARE_TICK),
    .last  (LINE_W'(ref_lpf - 1'b1)),
    .count (ref_cnt),
    .wrap  (ref_wrap)
  );

  // Input to output frame ratio
  assign ratio_last = (ratio_num == '0) ? '0 : RATIO_W'(ratio_num - 1'b1);

  fpag_wrap_counter #(.W(RATIO_W)) u_ratio (
    .clk   (REF_CLK),
    .rst   (RST),
    .clr   (trig_rise),
    .step  (ref_wrap),
    .last  (ratio_last),
    .count (ratio_cnt),
    .wrap  ()
  );

  // Offset equal to frame length means the frame start
  assign align_line = (line_ofs == ref_lpf) ? '0 : line_ofs;
  assign ref_point  = LINE_COMPARE_TICK && (ref_cnt == align_line)
                      && (ratio_cnt == '0);

  // Trigger edge in the counter domain
  assign trig_rise = trig_bit && !trig_q_ff;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      trig_q_ff <= 1'b0;
    end else begin
      trig_q_ff <= trig_bit;
    end
  end

  // Alignment mode
  always_ff @(posedge REF_CLK) begin
    if (RST || !align_en) begin
      armed_ff <= 1'b0;
    end else if (trig_rise) begin
      armed_ff <= 1'b1;
    end
  end

  // Both counters clear together so delays stay fixed afterwards
  assign align_now = armed_ff && align_en && ref_point;

  // Missing horizontal sync count, vertical sync plays no part
  always_ff @(posedge REF_CLK) begin
    if (RST || HSYNC_SEEN) begin
      miss_ff <= '0;
    end else if (HSYNC_MISSED && miss_ff != '1) begin
      miss_ff <= MISS_W'(miss_ff + 1'b1);
    end
  end

  assign ref_valid = HSYNC_FORMAT_MATCH && DIVIDER_MATCH && VCTRL_IN_RANGE
                     && (miss_ff <= LOSS_THRESHOLD);

  // Lock detectors
  fpag_lock_filter u_base_lock (
    .clk      (REF_CLK),
    .rst      (RST),
    .cmp_tick (LINE_COMPARE_TICK),
    .err_high (BASE_PHASE_ERR_HIGH),
    .locked   (base_locked)
  );

  fpag_lock_filter u_fast_lock (
    .clk      (REF_CLK),
    .rst      (RST),
    .cmp_tick (FAST_COMPARE_TICK),
    .err_high (FAST_PHASE_ERR_HIGH),
    .locked   (fast_locked)
  );

  // Output flops
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pulse_ff <= 1'b0;
      oe_ff    <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      pulse_ff <= (line_cnt == '0);
      oe_ff    <= !float_bit;
      event_ff <= align_now;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      no_ref_ff  <= 1'b1;
      no_lock_ff <= 1'b1;
    end else begin
      no_ref_ff  <= !ref_valid;
      no_lock_ff <= !(ref_valid && base_locked && fast_locked);
    end
  end

  assign REG_RDATA      = rdata_ff;
  assign FRAME_PULSE    = pulse_ff;
  assign FRAME_PULSE_OE = oe_ff;
  assign ALIGN_EVENT    = event_ff;
  assign NO_REF_FLAG    = no_ref_ff;
  assign NO_LOCK_FLAG   = no_lock_ff;

  // Checks
  AST_NO_REF: assert property (@(posedge REF_CLK) disable iff (RST)
    !HSYNC_FORMAT_MATCH |=> NO_REF_FLAG)
    else $error("no-reference flag low without format match");
  AST_NO_LOCK: assert property (@(posedge REF_CLK) disable iff (RST)
    1'b1 |=> NO_LOCK_FLAG == !($past(ref_valid) && $past(base_locked) && $past(fast_locked)))
    else $error("no-lock flag disagrees with status bits");
  AST_VCTRL: assert property (@(posedge REF_CLK) disable iff (RST)
    !VCTRL_IN_RANGE |-> !ref_valid)
    else $error("reference valid with control voltage near a rail");
  AST_MISS: assert property (@(posedge REF_CLK) disable iff (RST)
    (miss_ff > LOSS_THRESHOLD) |-> !ref_valid ##1 NO_REF_FLAG)
    else $error("reference loss not flagged");
  AST_FLOAT: assert property (@(posedge REF_CLK) disable iff (RST)
    float_bit |=> !FRAME_PULSE_OE)
    else $error("frame pulse driven while float bit set");
  AST_ALIGN: assert property (@(posedge REF_CLK) disable iff (RST)
    align_now |=> pix_cnt == '0 && line_cnt == '0 && ALIGN_EVENT)
    else $error("counters not cleared on alignment");
  AST_ALIGN_LINE: assert property (@(posedge REF_CLK) disable iff (RST)
    align_now |-> ref_cnt == align_line && ratio_cnt == '0)
    else $error("alignment away from the offset line");
  AST_ENABLE: assert property (@(posedge REF_CLK) disable iff (RST)
    !align_en |-> !align_now ##1 !armed_ff)
    else $error("alignment while mode disabled");
  AST_TRIG: assert property (@(posedge REF_CLK) disable iff (RST)
    (trig_bit && !$past(trig_bit) && align_en) |=> armed_ff && ratio_cnt == '0)
    else $error("trigger edge did not arm alignment");
  AST_REF_WRAP: assert property (@(posedge REF_CLK) disable iff (RST)
    ref_wrap |=> ref_cnt == '0)
    else $error("reference frame did not restart");
  AST_SEL: assert property (@(posedge REF_CLK) disable iff (RST)
    (!align_now && !pix_wrap) |=> pix_cnt == PPL_W'($past(pix_cnt)
      + $past(clk_sel ? HIGH_PIXEL_TICK : STD_PIXEL_TICK)))
    else $error("pixel counter did not follow the selected strobe");
  AST_PULSE: assert property (@(posedge REF_CLK) disable iff (RST)
    (line_cnt == '0) |=> FRAME_PULSE)
    else $error("frame pulse missing on first line");
  AST_STATUS: assert property (@(posedge REF_CLK) disable iff (RST)
    (REG_RD && REG_ADDR == ADDR_STATUS) |=> REG_RDATA[2:0] == $past(status[2:0]))
    else $error("status read wrong");

  COV_TRIG: cover property (@(posedge REF_CLK) disable iff (RST) trig_rise && align_en);
  COV_ALIGN: cover property (@(posedge REF_CLK) disable iff (RST) align_now);
  COV_LOSS: cover property (@(posedge REF_CLK) disable iff (RST) !NO_REF_FLAG ##1 NO_REF_FLAG);
  COV_LOCK: cover property (@(posedge REF_CLK) disable iff (RST) !NO_LOCK_FLAG);
endmodule
`default_nettype wire

/* File: bench/fpag_sync_source.sv */
// Sync source and pixel strobe model facing the frame pulse block.
// Assumes the bench sets strobe periods and whether a reference is present.
`timescale 1ns/100ps
`default_nettype none
module fpag_sync_source (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control from the bench
  input  wire logic       run,
  input  wire logic       ref_on,
  input  wire logic [7:0] std_per,
  input  wire logic [7:0] high_per,
  input  wire logic [7:0] cmp_per,
  // Strobes
  output logic            std_tick,
  output logic            high_tick,
  output logic            line_tick,
  output logic            fast_tick,
  output logic            hs_seen,
  output logic            hs_missed
);
  logic [7:0] std_cnt;
  logic [7:0] high_cnt;
  logic [7:0] cmp_cnt;
  // Strobes stand still while stopped
  always @(posedge clk) begin
    if (rst || !run) begin
      std_cnt <= 8'h00;
      high_cnt <= 8'h00;
      cmp_cnt <= 8'h00;
      {std_tick, high_tick, line_tick, fast_tick, hs_seen, hs_missed} <= 6'h00;
    end else begin
      std_cnt <= (std_cnt == std_per - 8'h01) ? 8'h00 : std_cnt + 8'h01;
      high_cnt <= (high_cnt == high_per - 8'h01) ? 8'h00 : high_cnt + 8'h01;
      cmp_cnt <= (cmp_cnt == cmp_per - 8'h01) ? 8'h00 : cmp_cnt + 8'h01;
      std_tick <= (std_cnt == std_per - 8'h01);
      high_tick <= (high_cnt == high_per - 8'h01);
      line_tick <= (cmp_cnt == cmp_per - 8'h01);
      fast_tick <= (cmp_cnt == cmp_per - 8'h01);
      // Presence shown by horizontal sync alone
      hs_seen <= (cmp_cnt == cmp_per - 8'h01) && ref_on;
      hs_missed <= (cmp_cnt == cmp_per - 8'h01) && !ref_on;
    end
  end
endmodule
`default_nettype wire

/* File: bench/frame_pulse_alignment_and_genlock_status_test.sv */
// Self-checking bench for the frame pulse and genlock status block.
// Assumes the sync source model supplies all strobes.
`timescale 1ns/100ps
`default_nettype none
module frame_pulse_alignment_and_genlock_status_test;
  import fpag_pkg::*;
  logic        ref_clk, rst, reg_wr, reg_rd, fmt_ok, div_ok, vc_ok;
  logic        base_err, fast_err, run, ref_on, fp, fp_oe, align_evt;
  logic        no_ref, no_lock, std_tick, high_tick, line_tick, fast_tick;
  logic        hs_seen, hs_missed;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, loss, std_per, high_per, cmp_per, d;
  int          error_cnt, cmp_count, cyc, t0, t1, t2, ppl, lines, rl, gap;
  int unsigned rv;

  fpag_top dut (
    .REF_CLK(ref_clk), .RST(rst),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .STD_PIXEL_TICK(std_tick), .HIGH_PIXEL_TICK(high_tick),
    .LINE_COMPARE_TICK(line_tick), .HSYNC_SEEN(hs_seen),
    .HSYNC_MISSED(hs_missed), .LOSS_THRESHOLD(loss),
    .HSYNC_FORMAT_MATCH(fmt_ok), .DIVIDER_MATCH(div_ok), .VCTRL_IN_RANGE(vc_ok),
    .FAST_COMPARE_TICK(fast_tick), .BASE_PHASE_ERR_HIGH(base_err),
    .FAST_PHASE_ERR_HIGH(fast_err), .FRAME_PULSE(fp), .FRAME_PULSE_OE(fp_oe),
    .ALIGN_EVENT(align_evt), .NO_REF_FLAG(no_ref), .NO_LOCK_FLAG(no_lock)
  );

  fpag_sync_source src (
    .clk(ref_clk), .rst(rst), .run(run), .ref_on(ref_on),
    .std_per(std_per), .high_per(high_per), .cmp_per(cmp_per),
    .std_tick(std_tick), .high_tick(high_tick), .line_tick(line_tick),
    .fast_tick(fast_tick), .hs_seen(hs_seen), .hs_missed(hs_missed)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Expected frame period and alignment spacing in clock cycles
  function automatic int frame_cyc(int p, int l, int per);
    return p * l * per;
  endfunction
  function automatic int align_gap(int r, int l, int per);
    return (r == 0 ? 1 : r) * l * per;
  endfunction

  task automatic report_and_stop;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic wait_fp(input logic lvl, output int at);
    int n;
    n = 0;
    while (fp !== lvl && n < 4000) begin
      tick(1);
      n++;
    end
    if (n == 4000) check(16'h0000, 16'h0001);
    at = cyc;
  endtask
  task automatic wait_evt(input int lim, output int at);
    at = -1;
    for (int n = 0; n < lim && at < 0; n++) begin
      tick(1);
      if (align_evt === 1'b1) at = cyc;
    end
  endtask
  task automatic wait_line(input logic missed);
    tick(1);
    while ((missed ? hs_missed : line_tick) !== 1'b1) tick(1);
    tick(4);
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    {rst, fmt_ok, div_ok, vc_ok, ref_on} = 5'h1f;
    {reg_wr, reg_rd, base_err, fast_err, run} = 5'h00;
    {reg_addr, reg_wdata, loss} = {8'h00, 8'h00, 8'h03};
    {std_per, high_per, cmp_per} = {8'h02, 8'h03, 8'h08};
    {error_cnt, cmp_count, cyc} = '0;
    rv = $urandom(64041);
    repeat (11) @(posedge ref_clk);
    #1;
    check({no_ref, no_lock, fp_oe}, 16'h0006);
    @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 20; a++) begin
      rd(a[7:0], d);
      if (a != 1) check(d, REG_RESET);
    end
    ppl = 3 + $urandom % 4;
    lines = 2 + $urandom % 3;
    rl = 3 + $urandom % 3;
    wr16(ADDR_PPL_LO, ppl[15:0]);
    wr16(ADDR_OLPF_LO, lines[15:0]);
    wr16(ADDR_RLPF_LO, rl[15:0]);
    wr16(ADDR_OFS_LO, 16'h0001 + $urandom % rl);
    @(posedge ref_clk);
    run <= 1'b1;
    for (int k = 1; k <= 3; k++) begin
      wait_line(1'b0);
      check(no_lock, k < 3);
    end
    rd(ADDR_STATUS, d);
    check(d, 8'h07);
    @(posedge ref_clk);
    base_err <= 1'b1;
    repeat (3) wait_line(1'b0);
    rd(ADDR_STATUS, d);
    check({d, 7'h00, no_lock}, 16'h0501);
    @(posedge ref_clk);
    base_err <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      @(posedge ref_clk);
      {fmt_ok, div_ok, vc_ok} <= c[2:0];
      tick(4);
      check(no_ref, c != 7);
      if (c != 7) check(no_lock, 1'b1);
    end
    @(posedge ref_clk);
    loss <= 8'($urandom % 4);
    ref_on <= 1'b0;
    for (int k = 1; k <= 4; k++) begin
      wait_line(1'b1);
      check(no_ref, k > loss);
    end
    rd(ADDR_STATUS, d);
    check(d[0], 1'b0);
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_PPL_HI, {s[0], 7'h00});
      wait_fp(1'b0, t0);
      wait_fp(1'b1, t0);
      wait_fp(1'b0, t1);
      wait_fp(1'b1, t2);
      check(t1 - t0, ppl * (s == 1 ? 3 : 2));
      check(t2 - t0, frame_cyc(ppl, lines, s == 1 ? 3 : 2));
    end
    @(posedge ref_clk);
    ref_on <= 1'b1;
    for (int r = 1; r <= 2; r++) begin
      gap = align_gap(r, rl, 8);
      wr(ADDR_RATIO_LO, r[7:0]);
      if (r == 2) wr16(ADDR_OFS_LO, rl[15:0]);
      wr(ADDR_ALIGN, 8'h00);
      wr(ADDR_ALIGN, 8'h80);
      wait_evt(gap * 2 + 20, t0);
      check(t0, -1);
      wr(ADDR_ALIGN, 8'hc0);
      wait_evt(gap + 40, t0);
      tick(1);
      check({fp, t0 < 0}, 16'h0002);
      wait_evt(gap + 20, t1);
      check(t1 - t0, gap);
      wr(ADDR_ALIGN, 8'h00);
      wait_evt(gap * 2 + 20, t2);
      check(t2, -1);
    end
    wr(ADDR_OUTCFG, 8'h10);
    tick(2);
    check(fp_oe, 1'b0);
    wr(ADDR_OUTCFG, 8'h00);
    tick(2);
    check(fp_oe, 1'b1);
    wr(ADDR_STATUS, 8'hf8);
    rd(ADDR_STATUS, d);
    check(d & 8'hf8, 8'h00);
    for (int a = 8; a <= 18; a++) begin
      rv = $urandom;
      wr(a[7:0], rv[7:0]);
      rd(a[7:0], d);
      check(d, rv[7:0]);
    end
    // Mid-run reset of one cycle
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check({fp, no_ref, no_lock, fp_oe, align_evt}, 16'h000c);
    tick(1);
    check({fp, no_ref, no_lock, fp_oe, align_evt}, 16'h0016);
    rd(ADDR_RLPF_LO, d);
    check(d, REG_RESET);
    report_and_stop();
  end
endmodule
`default_nettype wire
